// [fpg_guard.sv]
// Flash program/erase guard: frequency timing value, unlock checking,
// option-bit protection and command issue to the flash array.
// Assumes a plain register port on ref_clk; debug pins are asynchronous.
`timescale 1ns/1ps
`include "fpg_regs.svh"

// Overview of operation
// - Frequency high and low bytes form timing
// - Programmed read-protect blocks debug, bypass reads
// - Erased read-protect keeps reads, debug enabled
// - Reset locks; locked controller refuses user operations, debug mass erase still starts
// - Unlocked controller accepts program and erase
// - Out-of-order control or page write locks
// - Control write of zero restarts sequencing
// - Write guard zero blocks user operations
// - Write guard one permits program, page and mass erase
module fpg_guard #(
  parameter int unsigned        KEY_N    = 2,
  parameter logic [KEY_N*8-1:0] KEY_SEQ  = `FPG_KEY_SEQ,
  parameter int unsigned        OP_TICKS = `FPG_OP_TICKS
) (
  input  wire logic          ref_clk,          // 20 MHz system clock
  input  wire logic          rstn,             // Async reset, active low
  input  wire logic [7:0]    addr,             // Register address
  input  wire logic [7:0]    wdata,            // Register write data
  input  wire logic          wr,               // Write strobe
  input  wire logic          rd,               // Read strobe
  output logic      [7:0]    rdata,            // Read data, cycle after rd
  input  wire logic          dbg_read_pin,     // Debug port read request
  input  wire logic          bypass_pin,       // Controller bypass mode
  input  wire logic          dbg_mass_pin,     // Debug mass erase request
  output logic               user_read_grant,  // External flash read allowed
  output fpg_pkg::fpg_op_req_t op,             // Operation issued
  output logic               op_start,         // One-cycle start pulse
  output logic               busy,             // Operation in progress
  output logic               ms_tick,          // 1 ms enable while busy
  output logic      [15:0]   flash_clock_khz   // Joined timing value
);

  // ----------------------------------------------------------------------
  // Registers and synchronisers
  // ----------------------------------------------------------------------
  logic [7:0]  opt0;
  logic [7:0]  opt1;
  logic [7:0]  freq_hi;
  logic [7:0]  freq_lo;
  logic [7:0]  page;
  logic        err;
  logic [15:0] tick_cnt;
  logic [7:0]  op_cnt;
  logic [2:0]  s1;
  logic [2:0]  s2;
  logic        mass_d;
  fpg_pkg::fpg_seq_t seq_state;
  logic        unlocked;

  function automatic fpg_pkg::fpg_op_t cmd_kind(input logic [7:0] c);
    unique case (c)
      `FPG_CMD_PROG:       cmd_kind = fpg_pkg::FPG_OP_PROG;
      `FPG_CMD_PAGE_ERASE: cmd_kind = fpg_pkg::FPG_OP_PAGE;
      `FPG_CMD_MASS_ERASE: cmd_kind = fpg_pkg::FPG_OP_MASS;
      default:             cmd_kind = fpg_pkg::FPG_OP_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire               wr_ctrl  = wr && addr == `FPG_ADDR_CTRL;
  wire               wr_page  = wr && addr == `FPG_ADDR_PAGE;
  wire               wr_stat  = wr && addr == `FPG_ADDR_STAT;
  wire fpg_pkg::fpg_op_t kind = cmd_kind(wdata);
  wire               is_cmd   = kind != fpg_pkg::FPG_OP_NONE;
  wire               rp_open  = opt0[`FPG_OPT0_RP_BIT];
  wire               wp_open  = opt0[`FPG_OPT0_WP_BIT];
  // Out-of-range clock gives wrong pulse widths, so no operation starts
  wire               freq_ok  = flash_clock_khz >= `FPG_KHZ_MIN &&
                                flash_clock_khz <= `FPG_KHZ_MAX;
  wire               dbg_mass = s2[2];
  wire               dbg_go   = dbg_mass && !mass_d && !busy && freq_ok;
  wire               user_go  = wr_ctrl && is_cmd && unlocked && wp_open &&
                                freq_ok && !busy && !dbg_go;
  wire               refused  = wr_ctrl && is_cmd && !user_go;
  wire               ext_read = s2[0] || s2[1];
  wire               tick_end = tick_cnt == flash_clock_khz - 16'h0001;
  wire               op_end   = ms_tick && op_cnt == 8'(OP_TICKS - 1);

  assign flash_clock_khz = {freq_hi, freq_lo};

  fpg_unlock_seq #(
    .KEY_N   (KEY_N),
    .KEY_SEQ (KEY_SEQ)
  ) u_seq (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .ctrl_wr   (wr_ctrl),
    .page_wr   (wr_page),
    .wdata     (wdata),
    .cmd_legal (is_cmd),
    .state     (seq_state),
    .unlocked  (unlocked)
  );

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opt0    <= `FPG_OPT_ERASED;
      opt1    <= `FPG_OPT_ERASED;
      freq_hi <= 8'h00;
      freq_lo <= 8'h00;
      page    <= 8'h00;
    end else if (wr) begin
      if (addr == `FPG_ADDR_OPT0) opt0 <= wdata;
      if (addr == `FPG_ADDR_OPT1) opt1 <= wdata;
      if (addr == `FPG_ADDR_FREQ_HI) freq_hi <= wdata;
      if (addr == `FPG_ADDR_FREQ_LO) freq_lo <= wdata;
      if (wr_page) page <= wdata;
    end
  end

  // Refusal flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      err <= 1'b0;
    end else begin
      err <= refused || (err && !(wr_stat && wdata[`FPG_STAT_ERR_BIT]));
    end
  end

  // ----------------------------------------------------------------------
  // Operation issue and timing
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      op       <= '0;
      op_start <= 1'b0;
      busy     <= 1'b0;
    end else begin
      op_start <= dbg_go || user_go;
      if (dbg_go) begin
        op <= '{kind: fpg_pkg::FPG_OP_MASS, from_dbg: 1'b1, page: page};
      end else if (user_go) begin
        op <= '{kind: kind, from_dbg: 1'b0, page: page};
      end
      if (dbg_go || user_go) begin
        busy <= 1'b1;
      end else if (op_end) begin
        busy <= 1'b0;
      end
    end
  end

  // The millisecond enable counts flash_clock_khz system clocks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 16'h0000;
      ms_tick  <= 1'b0;
      op_cnt   <= 8'h00;
    end else begin
      ms_tick  <= busy && !ms_tick && tick_end;
      tick_cnt <= (!busy || tick_end) ? 16'h0000 : tick_cnt + 16'h0001;
      if (!busy) begin
        op_cnt <= 8'h00;
      end else if (ms_tick) begin
        op_cnt <= op_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers and read protection
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1              <= 3'h0;
      s2              <= 3'h0;
      mass_d          <= 1'b0;
      user_read_grant <= 1'b0;
    end else begin
      s1              <= {dbg_mass_pin, bypass_pin, dbg_read_pin};
      s2              <= s1;
      mass_d          <= dbg_mass;
      user_read_grant <= rp_open || !ext_read;
    end
  end

  // ----------------------------------------------------------------------
  // Read port: unmapped offsets read zero
  // ----------------------------------------------------------------------
  wire [7:0] stat_val = {4'h0, seq_state == fpg_pkg::FPG_IDLE, err, busy, unlocked};
  wire [7:0] rd_mux   = addr == `FPG_ADDR_OPT0    ? opt0    :
                        addr == `FPG_ADDR_OPT1    ? opt1    :
                        addr == `FPG_ADDR_PAGE    ? page    :
                        addr == `FPG_ADDR_FREQ_HI ? freq_hi :
                        addr == `FPG_ADDR_FREQ_LO ? freq_lo :
                        addr == `FPG_ADDR_STAT    ? stat_val : 8'h00;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_user_cmd;
    wr_ctrl && is_cmd && !busy && !dbg_go;
  endsequence

  a_locked_refuse: assert property (@(posedge ref_clk) disable iff (!rstn)
    op_start && !op.from_dbg |-> $past(unlocked))
    else $error("user operation started while locked");

  a_unlocked_accept: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_user_cmd and (unlocked && wp_open && freq_ok) |=> op_start && !op.from_dbg)
    else $error("unlocked command not started");

  a_guard_block: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_user_cmd and (!wp_open) |=> !op_start ##0 err)
    else $error("write guard did not refuse user command");

  a_dbg_mass_ok: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(dbg_mass) && !busy && freq_ok |=> op_start && op.from_dbg &&
    op.kind == fpg_pkg::FPG_OP_MASS)
    else $error("debug mass erase not started");

  a_read_block: assert property (@(posedge ref_clk) disable iff (!rstn)
    !rp_open && ext_read |=> !user_read_grant)
    else $error("protected flash readable externally");

  a_read_open: assert property (@(posedge ref_clk) disable iff (!rstn)
    rp_open |=> user_read_grant)
    else $error("erased read protect still blocks reads");

  a_freq_join: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr && addr == `FPG_ADDR_FREQ_HI |=> flash_clock_khz[15:8] == $past(wdata))
    else $error("high frequency byte not joined");

  a_freq_range: assert property (@(posedge ref_clk) disable iff (!rstn)
    op_start |-> $past(freq_ok))
    else $error("operation started with clock out of range");

  a_busy_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    op_start |-> busy [*2])
    else $error("busy not held after start");

endmodule

// [fpg_regs.svh]
// Register offsets, field positions, reset values and timing counts
// for the flash program/erase guard. Included by the guard and its sequencer.
`ifndef FPG_REGS_SVH
`define FPG_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (8-bit register port)
// ----------------------------------------------------------------------
`define FPG_ADDR_OPT0      8'h00
`define FPG_ADDR_OPT1      8'h01
`define FPG_ADDR_CTRL      8'h08
`define FPG_ADDR_PAGE      8'h09
`define FPG_ADDR_FREQ_HI   8'h0a
`define FPG_ADDR_FREQ_LO   8'h0b
`define FPG_ADDR_STAT      8'h0c

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define FPG_OPT_ERASED     8'hff
`define FPG_OPT0_RP_BIT    7
`define FPG_OPT0_WP_BIT    3
`define FPG_STAT_OPEN_BIT  0
`define FPG_STAT_BUSY_BIT  1
`define FPG_STAT_ERR_BIT   2

// ----------------------------------------------------------------------
// Control codes; key values are arbitrary
// ----------------------------------------------------------------------
`define FPG_CMD_RESET      8'h00
`define FPG_CMD_PROG       8'h97
`define FPG_CMD_PAGE_ERASE 8'h96
`define FPG_CMD_MASS_ERASE 8'h95
`define FPG_KEY_SEQ        16'h738c

// ----------------------------------------------------------------------
// Timing: supported clock range in kHz, operation length in 1 ms ticks
// ----------------------------------------------------------------------
`define FPG_KHZ_MIN        16'h0014
`define FPG_KHZ_MAX        16'h4e20
`define FPG_OP_TICKS       2

`endif

// [fpg_pkg.sv]
// Types shared by the flash program/erase guard and its unlock sequencer.
// Assumes fpg_regs.svh supplies the numeric constants.
package fpg_pkg;

  // Gray along idle -> step1 -> step2 -> keys -> open
  typedef enum logic [2:0] {
    FPG_IDLE  = 3'h0,
    FPG_STEP1 = 3'h1,
    FPG_STEP2 = 3'h3,
    FPG_KEYS  = 3'h2,
    FPG_OPEN  = 3'h6
  } fpg_seq_t;

  typedef enum logic [1:0] {
    FPG_OP_NONE  = 2'h0,
    FPG_OP_PROG  = 2'h1,
    FPG_OP_PAGE  = 2'h2,
    FPG_OP_MASS  = 2'h3
  } fpg_op_t;

  typedef struct packed {
    fpg_op_t    kind;
    logic       from_dbg;
    logic [7:0] page;
  } fpg_op_req_t;

endpackage

// [fpg_unlock_seq.sv]
// Unlock sequencer: watches control and page-select writes and opens
// the controller only after the complete ordered sequence.
// Assumes one-cycle write strobes on the same clock.
`timescale 1ns/1ps
`include "fpg_regs.svh"

module fpg_unlock_seq #(
  parameter int unsigned          KEY_N   = 2,
  parameter logic [KEY_N*8-1:0]   KEY_SEQ = `FPG_KEY_SEQ
) (
  input  wire logic             ref_clk,   // System clock
  input  wire logic             rstn,      // Async reset, active low
  input  wire logic             ctrl_wr,   // Control register write
  input  wire logic             page_wr,   // Page select write
  input  wire logic [7:0]       wdata,     // Write data
  input  wire logic             cmd_legal, // Write data is a known command
  output fpg_pkg::fpg_seq_t     state,     // Sequencer state
  output logic                  unlocked   // Controller open
);

  logic [3:0]        idx;
  logic [3:0]        next_idx;
  fpg_pkg::fpg_seq_t next_state;
  wire  [7:0]        key_now = KEY_SEQ[8*(KEY_N-1-int'(idx)) +: 8];
  wire               key_last = (idx == 4'(KEY_N-1));

  assign unlocked = (state == fpg_pkg::FPG_OPEN);

  always_comb begin
    next_state = state;
    next_idx   = idx;
    if (ctrl_wr && wdata == `FPG_CMD_RESET) begin
      next_state = fpg_pkg::FPG_STEP1;
      next_idx   = 4'h0;
    end else if (page_wr) begin
      next_state = (state == fpg_pkg::FPG_STEP1) ? fpg_pkg::FPG_STEP2
                                                  : fpg_pkg::FPG_IDLE;
    end else if (ctrl_wr) begin
      unique case (state)
        fpg_pkg::FPG_STEP2, fpg_pkg::FPG_KEYS: begin
          if (wdata == key_now) begin
            next_state = key_last ? fpg_pkg::FPG_OPEN : fpg_pkg::FPG_KEYS;
            next_idx   = idx + 4'h1;
          end else begin
            next_state = fpg_pkg::FPG_IDLE;
          end
        end
        fpg_pkg::FPG_OPEN: begin
          next_state = cmd_legal ? fpg_pkg::FPG_OPEN : fpg_pkg::FPG_IDLE;
        end
        default: begin
          next_state = fpg_pkg::FPG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= fpg_pkg::FPG_IDLE;
      idx   <= 4'h0;
    end else begin
      state <= next_state;
      idx   <= next_idx;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_restart_seq: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl_wr && wdata == `FPG_CMD_RESET |=> state == fpg_pkg::FPG_STEP1)
    else $error("control write of zero did not restart sequence");

  a_page_order: assert property (@(posedge ref_clk) disable iff (!rstn)
    page_wr && state != fpg_pkg::FPG_STEP1 |=> !unlocked && state == fpg_pkg::FPG_IDLE)
    else $error("out of order page write did not lock");

  a_open_by_key: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(unlocked) |-> $past(ctrl_wr) && $past(wdata) == KEY_SEQ[7:0])
    else $error("opened without last key");

endmodule

// [fpg_guard_tb.sv]
// Self-checking testbench for the flash program/erase guard.
// Assumes fpg_regs.svh and fpg_pkg are compiled before this file.
`timescale 1ns/1ps
`include "fpg_regs.svh"

module test_flash_program_erase_guard;
  logic                 ref_clk;
  logic                 rstn;
  logic [7:0]           addr;
  logic [7:0]           wdata;
  logic                 wr;
  logic                 rd;
  logic [7:0]           rdata;
  logic                 dbg_read_pin;
  logic                 bypass_pin;
  logic                 dbg_mass_pin;
  logic                 user_read_grant;
  fpg_pkg::fpg_op_req_t op;
  fpg_pkg::fpg_op_req_t last_op;
  logic                 op_start;
  logic                 busy;
  logic                 ms_tick;
  logic [15:0]          flash_clock_khz;
  int                   bad_count;
  int                   n_checks;
  int                   op_count;
  int                   n0;
  int                   tick_count;
  int                   t0;

  fpg_guard #(.OP_TICKS(1)) u_fpg_guard (
    .ref_clk         (ref_clk),
    .rstn            (rstn),
    .addr            (addr),
    .wdata           (wdata),
    .wr              (wr),
    .rd              (rd),
    .rdata           (rdata),
    .dbg_read_pin    (dbg_read_pin),
    .bypass_pin      (bypass_pin),
    .dbg_mass_pin    (dbg_mass_pin),
    .user_read_grant (user_read_grant),
    .op              (op),
    .op_start        (op_start),
    .busy            (busy),
    .ms_tick         (ms_tick),
    .flash_clock_khz (flash_clock_khz)
  );

  // ----------------------------------------------------------------------
  // Clock, issued-operation monitor and watchdog
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // The start pulse lasts one cycle, so every edge is watched
  always @(posedge ref_clk) begin
    if (op_start === 1'b1) begin
      op_count++;
      last_op = op;
    end
    if (ms_tick === 1'b1) begin
      tick_count++;
    end
  end

  initial begin
    #(50 * 20000);
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
    chk({8'h00, d & m}, {8'h00, exp});
  endtask

  task automatic unlock(input logic [7:0] page);
    wr_reg(`FPG_ADDR_CTRL, `FPG_CMD_RESET);
    wr_reg(`FPG_ADDR_PAGE, page);
    wr_reg(`FPG_ADDR_CTRL, 8'h73);
    wr_reg(`FPG_ADDR_CTRL, 8'h8c);
  endtask

  // A debug request crosses the pin synchroniser first, so busy rises late
  task automatic wait_idle();
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge ref_clk);
    chk({15'h0000, busy}, 16'h0000);
  endtask

  task automatic do_op(input logic [7:0] cmd, input fpg_pkg::fpg_op_t k, input logic [7:0] pg);
    n0 = op_count;
    t0 = tick_count;
    wr_reg(`FPG_ADDR_CTRL, cmd);
    wait_idle();
    chk(16'(op_count), 16'(n0 + 1));
    chk({5'h00, last_op}, {5'h00, k, 1'b0, pg});
    // The instance runs one millisecond tick per operation
    chk(16'(tick_count), 16'(t0 + 1));
  endtask

  // A refused command issues nothing and raises the error flag
  task automatic refused(input logic [7:0] cmd);
    n0 = op_count;
    wr_reg(`FPG_ADDR_CTRL, cmd);
    repeat (3) @(posedge ref_clk);
    chk(16'(op_count), 16'(n0));
    rchk(`FPG_ADDR_STAT, 8'h06, 8'h04);
    wr_reg(`FPG_ADDR_STAT, 8'h04);
  endtask

  task automatic pins(input logic r, input logic b, input logic exp);
    @(posedge ref_clk);
    dbg_read_pin <= r;
    bypass_pin   <= b;
    repeat (6) @(posedge ref_clk);
    chk({15'h0000, user_read_grant}, {15'h0000, exp});
  endtask

  task automatic end_of_test();
    $display("Checks: %0d, mismatches: %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    rstn = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    dbg_read_pin = 1'b0; bypass_pin = 1'b0; dbg_mass_pin = 1'b0;
    bad_count = 0; n_checks = 0; op_count = 0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;

    rchk(`FPG_ADDR_OPT0, 8'hff, 8'hff);
    rchk(`FPG_ADDR_OPT1, 8'hff, 8'hff);
    rchk(`FPG_ADDR_STAT, 8'hff, 8'h08);
    rchk(8'h30, 8'hff, 8'h00);
    rchk(`FPG_ADDR_CTRL, 8'hff, 8'h00);
    $display("Test reset_values done");

    wr_reg(`FPG_ADDR_FREQ_HI, 8'h12);
    wr_reg(`FPG_ADDR_FREQ_LO, 8'h34);
    #1;
    chk(flash_clock_khz, 16'h1234);
    // The 20 MHz bench clock is 20000 kHz
    wr_reg(`FPG_ADDR_FREQ_HI, 8'h4e);
    wr_reg(`FPG_ADDR_FREQ_LO, 8'h20);
    #1;
    chk(flash_clock_khz, 16'h4e20);
    // Lowest legal value keeps operations short
    wr_reg(`FPG_ADDR_FREQ_HI, 8'h00);
    wr_reg(`FPG_ADDR_FREQ_LO, 8'h14);
    #1;
    chk(flash_clock_khz, 16'h0014);
    $display("Test timing_value done");

    refused(`FPG_CMD_PROG);
    wr_reg(`FPG_ADDR_CTRL, `FPG_CMD_RESET);
    wr_reg(`FPG_ADDR_PAGE, 8'h03);
    wr_reg(`FPG_ADDR_CTRL, 8'h73);
    refused(`FPG_CMD_PROG);
    wr_reg(`FPG_ADDR_CTRL, `FPG_CMD_RESET);
    wr_reg(`FPG_ADDR_PAGE, 8'h03);
    wr_reg(`FPG_ADDR_PAGE, 8'h03);
    wr_reg(`FPG_ADDR_CTRL, 8'h73);
    wr_reg(`FPG_ADDR_CTRL, 8'h8c);
    rchk(`FPG_ADDR_STAT, 8'h01, 8'h00);
    $display("Test locked_refusal done");

    unlock(8'h05);
    rchk(`FPG_ADDR_STAT, 8'h01, 8'h01);
    do_op(`FPG_CMD_PROG, fpg_pkg::FPG_OP_PROG, 8'h05);
    do_op(`FPG_CMD_PAGE_ERASE, fpg_pkg::FPG_OP_PAGE, 8'h05);
    do_op(`FPG_CMD_MASS_ERASE, fpg_pkg::FPG_OP_MASS, 8'h05);
    wr_reg(`FPG_ADDR_FREQ_LO, 8'h13);
    refused(`FPG_CMD_PROG);
    wr_reg(`FPG_ADDR_FREQ_HI, 8'h4e);
    wr_reg(`FPG_ADDR_FREQ_LO, 8'h21);
    refused(`FPG_CMD_PAGE_ERASE);
    wr_reg(`FPG_ADDR_FREQ_HI, 8'h00);
    wr_reg(`FPG_ADDR_FREQ_LO, 8'h14);
    wr_reg(`FPG_ADDR_PAGE, 8'h06);
    rchk(`FPG_ADDR_STAT, 8'h01, 8'h00);
    refused(`FPG_CMD_PROG);
    $display("Test unlock_and_ops done");

    wr_reg(`FPG_ADDR_OPT0, 8'hf7);
    unlock(8'h07);
    refused(`FPG_CMD_PROG);
    refused(`FPG_CMD_PAGE_ERASE);
    refused(`FPG_CMD_MASS_ERASE);
    n0 = op_count;
    dbg_mass_pin <= 1'b1;
    wait_idle();
    chk(16'(op_count), 16'(n0 + 1));
    chk({5'h00, last_op}, {5'h00, fpg_pkg::FPG_OP_MASS, 1'b1, 8'h07});
    dbg_mass_pin <= 1'b0;
    $display("Test write_guard done");

    wr_reg(`FPG_ADDR_OPT0, 8'hff);
    pins(1'b1, 1'b1, 1'b1);
    wr_reg(`FPG_ADDR_OPT0, 8'h7f);
    repeat (2) @(posedge ref_clk);
    chk({15'h0000, user_read_grant}, 16'h0000);
    pins(1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b0, 1'b1);
    $display("Test read_protect done");

    unlock(8'h02);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rchk(`FPG_ADDR_STAT, 8'hff, 8'h08);
    refused(`FPG_CMD_PROG);
    $display("Test second_reset done");
    end_of_test();
  end
endmodule
